// [rx_acq_regs.vh]
`ifndef RX_ACQ_REGS_VH
`define RX_ACQ_REGS_VH
// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_TASK 8'h04
`define OFF_STATUS 8'h08
`define OFF_DATA 8'h0c
`define OFF_BITDIV 8'h10
// Control fields
`define CTRL_DIR 0
`define CTRL_LEVACQ 1
`define CTRL_CLKACQ 2
`define CTRL_LEVSEL_LO 4
`define CTRL_BWSEL_LO 6
// Task codes
`define TASK_IDLE 3'h0
`define TASK_LOAD_SYNC 3'h1
`define TASK_SEARCH_HEAD 3'h2
`define TASK_SEARCH_SHORT 3'h3
`define TASK_READ_BLOCK 3'h4
// Timing counts in bit periods, block length in bytes, divider reset value
`define CLAMP_BITS 6'h01
`define LEV_SEARCH_BITS 6'h1c
`define LEV_TIMEOUT_BITS 6'h1e
`define CLK_SEARCH_BITS 6'h0e
`define WIDE_BITS 6'h10
`define MEDIUM_BITS 6'h1e
`define BLOCK_BYTES 5'h12
`define BITDIV_RESET 16'h61a8
`endif

// [rx_acquisition_sequencer.v]
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rx_acq_regs.vh"
// Summary of operation
// - Interrupt after second sync byte taken
// - Head interrupt after sync found, decoded
// - Block interrupt after block and CRC
// - Idle automatically when no new task
// - Level: one bit clamp, then lossy peak
// - Early search keeps lossy peak until sync
// - Otherwise residual level after thirty bits
// - Residual level is the fixed LV_RESID mode
// - Early search keeps wide until sync
// - Otherwise wide sixteen bits, then medium
// - Medium thirty bits, then residual bandwidth
module rx_acquisition_sequencer
(
	input wire clk,
	input wire rst_n,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire sync_found,
	input wire head_check_ok,
	input wire address_match,
	input wire byte_done,
	input wire crc_ok,
	output reg host_irq_n,
	output reg [1:0] level_mode,
	output reg [1:0] bw_mode,
	output reg [2:0] active_task
);
	// Level modes and bandwidth modes
	localparam LV_CLAMP = 2'h0;
	localparam LV_LOSSY = 2'h1;
	localparam LV_RESID = 2'h2;
	localparam BW_WIDE = 2'h0;
	localparam BW_MED = 2'h1;
	localparam BW_RESID = 2'h2;
	localparam BW_IDLE = 2'h3;
	reg [2:0] sync_s1_q, sync_s2_q, sync_s3_q;
	reg sync_hi_q;
	wire sync_ev;
	reg [7:0] ctrl_q;
	reg [15:0] bitdiv_q;
	reg [15:0] div_cnt_q;
	wire bit_tick;
	reg [5:0] lev_cnt_q, clk_cnt_q;
	reg lev_search_q, clk_search_q, lev_on_q, clk_on_q;
	reg [4:0] byte_cnt_q;
	reg address_match_flag_q, head_check_flag_q, crc_flag_q;
	reg [7:0] sync_byte_q [0:1];
	reg aw_q, w_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire wr_go;
	wire task_wr;
	wire ctrl_wr;
	wire search_wr;
	reg byte_ev_q, byte_hi_q;
	// Write channel capture, either order
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;
	assign wr_go = aw_q && w_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign task_wr = wr_go && awaddr_q == `OFF_TASK && wstrb_q[0];
	assign ctrl_wr = wr_go && awaddr_q == `OFF_CTRL && wstrb_q[0];
	assign search_wr = task_wr && (wdata_q[2:0] == `TASK_SEARCH_HEAD ||
		wdata_q[2:0] == `TASK_SEARCH_SHORT);
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q <= `OFF_BITDIV &&
					awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// Read channel
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`OFF_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
			`OFF_TASK: s_axi_rdata <= {29'h0, active_task};
			`OFF_STATUS: s_axi_rdata <= {19'h0, byte_cnt_q,
				bw_mode, level_mode, 1'b0, crc_flag_q,
				head_check_flag_q, address_match_flag_q};
			`OFF_DATA: s_axi_rdata <= {16'h0, sync_byte_q[1],
				sync_byte_q[0]};
			`OFF_BITDIV: s_axi_rdata <= {16'h0, bitdiv_q};
			default:
			begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	// Pin synchronisers for demodulator events
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync_s1_q <= 3'h0;
			sync_s2_q <= 3'h0;
			sync_s3_q <= 3'h0;
			sync_hi_q <= 1'b0;
			byte_hi_q <= 1'b0;
		end
		else
		begin
			sync_s1_q <= {byte_done, sync_found, 1'b0};
			sync_s2_q <= sync_s1_q;
			sync_s3_q <= sync_s2_q;
			if (sync_s2_q[1] == sync_s3_q[1])
				sync_hi_q <= sync_s3_q[1];
			if (sync_s2_q[2] == sync_s3_q[2])
				byte_hi_q <= sync_s3_q[2];
		end
	end
	assign sync_ev = sync_s2_q[1] && sync_s3_q[1] && !sync_hi_q;
	always @(posedge clk)
	begin
		if (!rst_n)
			byte_ev_q <= 1'b0;
		else
			byte_ev_q <= sync_s2_q[2] && sync_s3_q[2] && !byte_hi_q;
	end
	// Bit period divider, restarted by acquisition writes
	assign bit_tick = div_cnt_q == 16'h0;
	always @(posedge clk)
	begin
		if (!rst_n)
			div_cnt_q <= `BITDIV_RESET;
		else if (ctrl_wr && (wdata_q[`CTRL_LEVACQ] ||
			wdata_q[`CTRL_CLKACQ]))
			div_cnt_q <= bitdiv_q;
		else if (bit_tick)
			div_cnt_q <= bitdiv_q;
		else
			div_cnt_q <= div_cnt_q - 16'h1;
	end
	// Control and divider registers
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_q <= 8'h00;
			bitdiv_q <= `BITDIV_RESET;
			sync_byte_q[0] <= 8'h00;
			sync_byte_q[1] <= 8'h00;
		end
		else
		begin
			// Residual selections kept, command bits self-clear
			if (ctrl_wr)
				ctrl_q <= {wdata_q[7:4], 3'h0, wdata_q[`CTRL_DIR]};
			if (wr_go && awaddr_q == `OFF_BITDIV)
				bitdiv_q <= wdata_q[15:0];
			if (wr_go && awaddr_q == `OFF_DATA)
			begin
				sync_byte_q[0] <= wdata_q[7:0];
				sync_byte_q[1] <= wdata_q[15:8];
			end
		end
	end
	// Level acquisition sequence
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			lev_cnt_q <= 6'h0;
			lev_search_q <= 1'b0;
			lev_on_q <= 1'b0;
			level_mode <= LV_RESID;
		end
		else if (ctrl_wr && wdata_q[`CTRL_LEVACQ])
		begin
			lev_cnt_q <= 6'h0;
			lev_search_q <= 1'b0;
			lev_on_q <= 1'b1;
			level_mode <= LV_CLAMP;
		end
		else if (lev_on_q)
		begin
			if (search_wr && lev_cnt_q <= `LEV_SEARCH_BITS)
				lev_search_q <= 1'b1;
			if (bit_tick && lev_cnt_q != 6'h3f)
				lev_cnt_q <= lev_cnt_q + 6'h1;
			if (level_mode == LV_CLAMP && bit_tick &&
				lev_cnt_q + 6'h1 >= `CLAMP_BITS)
				level_mode <= LV_LOSSY;
			else if (level_mode == LV_LOSSY)
			begin
				if (lev_search_q && sync_ev)
				begin
					level_mode <= LV_RESID;
					lev_on_q <= 1'b0;
				end
				else if (!lev_search_q && bit_tick &&
					lev_cnt_q + 6'h1 >= `LEV_TIMEOUT_BITS)
				begin
					level_mode <= LV_RESID;
					lev_on_q <= 1'b0;
				end
			end
		end
	end
	// Clock acquisition sequence
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			clk_cnt_q <= 6'h0;
			clk_search_q <= 1'b0;
			clk_on_q <= 1'b0;
			bw_mode <= BW_RESID;
		end
		else if (ctrl_wr && wdata_q[`CTRL_CLKACQ])
		begin
			clk_cnt_q <= 6'h0;
			clk_search_q <= 1'b0;
			clk_on_q <= 1'b1;
			bw_mode <= BW_WIDE;
		end
		else if (clk_on_q)
		begin
			if (search_wr && clk_cnt_q <= `CLK_SEARCH_BITS &&
				bw_mode == BW_WIDE)
				clk_search_q <= 1'b1;
			if (bit_tick)
				clk_cnt_q <= clk_cnt_q + 6'h1;
			case (bw_mode)
			BW_WIDE:
				if ((clk_search_q && sync_ev) || (!clk_search_q &&
					bit_tick && clk_cnt_q + 6'h1 >= `WIDE_BITS))
				begin
					bw_mode <= BW_MED;
					clk_cnt_q <= 6'h0;
				end
			BW_MED:
				if (bit_tick && clk_cnt_q + 6'h1 >= `MEDIUM_BITS)
				begin
					bw_mode <= BW_RESID;
					clk_on_q <= 1'b0;
				end
			default: clk_on_q <= 1'b0;
			endcase
		end
	end
	// Task flow and host interrupt
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			active_task <= `TASK_IDLE;
			host_irq_n <= 1'b1;
			byte_cnt_q <= 5'h0;
			address_match_flag_q <= 1'b0;
			head_check_flag_q <= 1'b0;
			crc_flag_q <= 1'b0;
		end
		else if (task_wr)
		begin
			active_task <= wdata_q[2:0];
			byte_cnt_q <= 5'h0;
			host_irq_n <= 1'b1;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready &&
				s_axi_araddr == `OFF_STATUS)
				host_irq_n <= 1'b1;
			case (active_task)
			`TASK_LOAD_SYNC:
				if (byte_ev_q)
				begin
					byte_cnt_q <= byte_cnt_q + 5'h1;
					if (byte_cnt_q == 5'h1)
					begin
						host_irq_n <= 1'b0;
						active_task <= `TASK_IDLE;
					end
				end
			`TASK_SEARCH_HEAD, `TASK_SEARCH_SHORT:
				if (sync_ev)
				begin
					address_match_flag_q <= address_match;
					head_check_flag_q <= head_check_ok;
					host_irq_n <= 1'b0;
					active_task <= `TASK_IDLE;
				end
			`TASK_READ_BLOCK:
				if (byte_ev_q)
				begin
					byte_cnt_q <= byte_cnt_q + 5'h1;
					if (byte_cnt_q + 5'h1 == `BLOCK_BYTES)
					begin
						crc_flag_q <= crc_ok;
						host_irq_n <= 1'b0;
						active_task <= `TASK_IDLE;
					end
				end
			default: active_task <= `TASK_IDLE;
			endcase
		end
	end
endmodule

// [rx_acq_properties.sv]
`timescale 1ns/1ps
module rx_acq_properties
(
	input wire clk,
	input wire rst_n,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire host_irq_n,
	input wire [1:0] level_mode,
	input wire [1:0] bw_mode,
	input wire [2:0] active_task
);
default clocking @(posedge clk);
endclocking
default disable iff (!rst_n);
AST_RST: assert property ($rose(rst_n) |-> host_irq_n
	&& active_task == 3'h0 && level_mode == 2'h2) else $error("reset");
AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
	else $error("bvalid dropped");
AST_CLAMP: assert property ($rose(level_mode == 2'h0) |->
	##[1:40] level_mode != 2'h0) else $error("clamp too long");
AST_LEV_ORDER: assert property (level_mode == 2'h0 ##1
	level_mode != 2'h0 |-> level_mode == 2'h1) else $error("no lossy");
AST_LEV_RES: assert property (level_mode == 2'h1 ##1
	level_mode != 2'h1 |-> level_mode == 2'h2) else $error("no residual");
AST_BW_MED: assert property (bw_mode == 2'h0 ##1
	bw_mode != 2'h0 |-> bw_mode == 2'h1) else $error("no medium");
AST_BW_RES: assert property (bw_mode == 2'h1 ##1
	bw_mode != 2'h1 |-> bw_mode == 2'h2) else $error("no residual bw");
AST_IRQ_SRC: assert property ($fell(host_irq_n) |->
	$past(active_task) != 3'h0) else $error("irq without task");
endmodule

// [rx_demod_model.sv]
`timescale 1ns/1ps
module rx_demod_model
(
	input wire clk,
	input wire [2:0] active_task,
	output reg sync_found = 1'b0,
	output reg byte_done = 1'b0
);
reg [8:0] cnt_q = 9'h000;
always @(posedge clk)
begin
	cnt_q <= (active_task == 3'h0) ? 9'h000 : cnt_q + 9'h001;
	// Sync late, after a long preamble
	sync_found <= active_task[2:1] == 2'b01 && cnt_q[8:7] == 2'b11;
	// A byte every four clocks; trailing extra bytes ignored
	byte_done <= cnt_q[1] && (active_task == 3'h1 ||
		active_task == 3'h4 || sync_found);
end
endmodule

// [tb_rx_acquisition_sequencer.sv]
`timescale 1ns/1ps
`include "rx_acq_regs.vh"
module tb_rx_acquisition_sequencer;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg [7:0] awaddr = 8'h00;
reg [7:0] araddr = 8'h00;
reg [31:0] wdata = 32'h0;
reg awvalid = 1'b0;
reg wvalid = 1'b0;
reg bready = 1'b0;
reg arvalid = 1'b0;
reg rready = 1'b0;
reg flag = 1'b1;
wire awready, wready, bvalid, arready, rvalid, sync_found, byte_done;
wire host_irq_n;
wire [1:0] bresp, rresp, level_mode, bw_mode;
wire [2:0] active_task;
wire [31:0] rdata;
integer mismatches = 0;
integer n_tests = 0;
integer i;
reg [31:0] d;
reg [1:0] r;
initial forever #2.5 clk = ~clk;
rx_acquisition_sequencer i_dut (.clk, .rst_n, .s_axi_awaddr(awaddr),
	.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
	.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
	.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
	.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
	.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
	.s_axi_rready(rready), .sync_found, .byte_done, .head_check_ok(flag),
	.address_match(flag), .crc_ok(flag), .host_irq_n, .level_mode, .bw_mode,
	.active_task);
rx_demod_model i_demod (.clk, .active_task, .sync_found, .byte_done);
task conclude;
begin
	$display("Checks %0d mismatches %0d", n_tests, mismatches);
	if (mismatches == 0 && n_tests > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
end
endtask
task chk(input string nm, input [31:0] e, input [31:0] s);
begin
	n_tests = n_tests + 1;
	if (s !== e)
	begin
		$display("Error %s exp %h got %h", nm, e, s);
		mismatches = mismatches + 1;
	end
end
endtask
task tmo;
begin
	mismatches = mismatches + 1;
	$display("Error wait exp 0 got 1");
	conclude;
end
endtask
task wr(input [7:0] a, input [31:0] v);
begin
	awaddr <= a;
	wdata <= v;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	for (i = 0; i < 99 && bvalid !== 1'b1; i = i + 1)
	begin
		@(posedge clk);
		if (awready) awvalid <= 1'b0;
		if (wready) wvalid <= 1'b0;
	end
	if (i == 99) tmo;
	bready <= 1'b0;
	@(posedge clk);
end
endtask
task rd(input [7:0] a);
begin
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	for (i = 0; i < 99 && rvalid !== 1'b1; i = i + 1)
	begin
		@(posedge clk);
		if (arready) arvalid <= 1'b0;
	end
	if (i == 99) tmo;
	d = rdata;
	r = rresp;
	rready <= 1'b0;
	@(posedge clk);
end
endtask
// Wait for idle task (sel) or interrupt
task wsig(input sel);
begin
	for (i = 0; i < 3000 && (sel ? active_task !== 3'h0
		: host_irq_n !== 1'b0); i = i + 1)
		@(posedge clk);
	if (i == 3000) tmo;
end
endtask
task pc(input integer n, input [1:0] e, input sel);
begin
	repeat (n) @(posedge clk);
	if (sel) chk("bw_mode", e, bw_mode);
	else chk("level_mode", e, level_mode);
end
endtask
task t_reg;
begin
	rd(`OFF_BITDIV);
	chk("bitdiv", {16'h0000, `BITDIV_RESET}, d);
	rd(8'h20);
	chk("rresp", 2'h2, r);
	wr(`OFF_BITDIV, 32'h0000000f);
	$display("t_reg done");
end
endtask
task t_timed;
begin
	wr(`OFF_CTRL, 32'h00000006);
	pc(2, 2'h0, 1'b0);
	pc(220, 2'h0, 1'b1);
	pc(64, 2'h1, 1'b1);
	pc(160, 2'h1, 1'b0);
	pc(64, 2'h2, 1'b0);
	pc(192, 2'h1, 1'b1);
	pc(64, 2'h2, 1'b1);
	$display("t_timed done");
end
endtask
task t_frame;
begin
	wr(`OFF_DATA, 32'h0000c33c);
	wr(`OFF_TASK, {29'h0, `TASK_LOAD_SYNC});
	wr(`OFF_CTRL, 32'h00000006);
	wsig(1'b0);
	rd(`OFF_STATUS);
	chk("host_irq_n", 1'b1, host_irq_n);
	repeat (192) @(posedge clk);
	wr(`OFF_TASK, {29'h0, `TASK_SEARCH_HEAD});
	pc(320, 2'h1, 1'b0);
	pc(0, 2'h0, 1'b1);
	wsig(1'b0);
	pc(0, 2'h2, 1'b0);
	pc(0, 2'h1, 1'b1);
	rd(`OFF_STATUS);
	chk("flags", 2'h3, d[1:0]);
	wr(`OFF_TASK, {29'h0, `TASK_READ_BLOCK});
	wsig(1'b0);
	rd(`OFF_STATUS);
	chk("crc", 1'b1, d[2]);
	wsig(1'b1);
	pc(0, 2'h1, 1'b1);
	pc(440, 2'h2, 1'b1);
	$display("t_frame done");
end
endtask
initial
begin
	repeat (2) @(posedge clk);
	rst_n <= 1'b1;
	@(posedge clk);
	t_reg;
	t_timed;
	t_frame;
	conclude;
end
endmodule
bind rx_acquisition_sequencer rx_acq_properties i_chk (.clk, .rst_n,
	.s_axi_bvalid, .s_axi_bready, .host_irq_n, .level_mode, .bw_mode,
	.active_task);
